//--- shared/atosc_defines.vh
// register map, field positions, reset values and timing counts for the converter control
`ifndef ATOSC_DEFINES_VH
`define ATOSC_DEFINES_VH

// register byte offsets
`define ATOSC_CTRL_OFS 8'h00
`define ATOSC_OVS_OFS 8'h04
`define ATOSC_STAT_OFS 8'h08
`define ATOSC_RDATA_OFS 8'h0C
`define ATOSC_SWST_OFS 8'h10

// control register fields
`define ATOSC_CTRL_ON 0
`define ATOSC_CTRL_DMA 1
`define ATOSC_CTRL_TSV 2
`define ATOSC_CTRL_RTE 3
`define ATOSC_CTRL_ITE 4
`define ATOSC_CTRL_RSEL_LO 8
`define ATOSC_CTRL_RSEL_HI 10
`define ATOSC_CTRL_ISEL_LO 12
`define ATOSC_CTRL_ISEL_HI 14
`define ATOSC_CTRL_SYNC_LO 16
`define ATOSC_CTRL_SYNC_HI 19
`define ATOSC_CTRL_MASK 32'h000F771F
`define ATOSC_CTRL_RST 32'h00000000

// oversampling register fields
`define ATOSC_OVS_EN 0
`define ATOSC_OVS_RATIO_LO 2
`define ATOSC_OVS_RATIO_HI 4
`define ATOSC_OVS_SHIFT_LO 5
`define ATOSC_OVS_SHIFT_HI 8
`define ATOSC_OVS_RES_LO 12
`define ATOSC_OVS_RES_HI 13
`define ATOSC_OVS_MASK 32'h000031FD
`define ATOSC_OVS_RST 32'h00000000

// software start register bits
`define ATOSC_SWST_REG 0
`define ATOSC_SWST_INS 1

// half-cycle timing: conversion phase in half converter cycles per resolution
`define ATOSC_TCONV_12_HALF 8'h19
`define ATOSC_TCONV_10_HALF 8'h15
`define ATOSC_TCONV_8_HALF 8'h11
`define ATOSC_TCONV_6_HALF 8'h0D
`define ATOSC_TSMPL_MIN_HALF 8'h03

// sync mode codes
`define ATOSC_SYNC_FREE 4'h0
`define ATOSC_SYNC_LAST 4'h9

`endif

//--- design/atosc_trig_sel.v
// trigger source selector with rising edge detection for one conversion group
`timescale 1ns/1ps
module atosc_trig_sel (
	input wire hclk,
	input wire hresetn,
	input wire [5:0] timer_event,
	input wire ext_line,
	input wire software_start,
	input wire [2:0] trigger_select,
	input wire trigger_enable,
	output reg trigger_pulse
);
	reg [6:0] sync_a;
	reg [6:0] sync_b;
	reg [6:0] last;
	wire [7:0] level;
	wire [7:0] prev;

	// two-flop synchronisers for every asynchronous source
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_a <= 7'h00;
			sync_b <= 7'h00;
			last <= 7'h00;
		end else begin
			sync_a <= {ext_line, timer_event};
			sync_b <= sync_a;
			last <= sync_b;
		end
	end

	// codes 0..5 timers, 6 external line, 7 software start
	assign level = {1'b0, sync_b};
	// widened like level so every select code indexes a real bit
	assign prev = {1'b0, last};

	// only rising edges start a conversion; software start is already a pulse
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trigger_pulse <= 1'b0;
		end else if (trigger_select == 3'h7) begin
			trigger_pulse <= software_start;
		end else begin
			trigger_pulse <= trigger_enable & level[trigger_select] & ~prev[trigger_select];
		end
	end
endmodule // atosc_trig_sel

//--- design/atosc_oversample.v
// oversampling accumulator with shift, rounding and 16-bit truncation
`timescale 1ns/1ps
module atosc_oversample (
	input wire hclk,
	input wire hresetn,
	input wire enable,
	input wire [2:0] oversample_ratio,
	input wire [3:0] oversample_shift,
	input wire sample_valid,
	input wire [11:0] sample_data,
	output reg result_valid,
	output reg [15:0] result_data
);
	reg [19:0] acc;
	reg [8:0] count;
	wire [8:0] ratio_n;
	wire [20:0] sum;
	wire [20:0] rounded;
	wire [20:0] shifted;
	wire [20:0] half;

	// ratio is two to the power of code plus one
	assign ratio_n = 9'h002 << oversample_ratio;
	assign sum = {1'b0, acc} + {9'h000, sample_data};
	// add half of the discarded weight to round to nearest
	assign half = (oversample_shift == 4'h0) ? 21'h000000 : (21'h000001 << (oversample_shift - 4'h1));
	assign rounded = sum + half;
	assign shifted = rounded >> oversample_shift;

	// one result every ratio conversions; timing of each conversion is untouched
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc <= 20'h00000;
			count <= 9'h000;
			result_valid <= 1'b0;
			result_data <= 16'h0000;
		end else begin
			result_valid <= 1'b0;
			if (!enable) begin
				acc <= 20'h00000;
				count <= 9'h000;
				if (sample_valid) begin
					result_valid <= 1'b1;
					result_data <= {4'h0, sample_data};
				end
			end else if (sample_valid) begin
				if (count + 9'h001 >= ratio_n) begin
					acc <= 20'h00000;
					count <= 9'h000;
					result_valid <= 1'b1;
					result_data <= shifted[15:0];
				end else begin
					acc <= sum[19:0];
					count <= count + 9'h001;
				end
			end
		end
	end
endmodule // atosc_oversample

//--- design/atosc_ctrl.v
// converter control top: triggers, timing, oversampling, dma and sync over ahb-lite
// Operation
// - regular trigger codes 0-5 timers, 6 external line, 7 software start
// - inserted trigger codes 0-5 timers, 6 second external line, 7 software start
// - a selected external source starts a conversion on its rising edge only
// - dma requests for regular results only while dma enable is set
// - one dma request per regular conversion; dma reads the result register; with oversampling on, a request follows only every n-th conversion
// - sensor enable makes channels 16 and 17 available
// - clearing sensor enable powers the temperature sensor down
// - resolution 12/10/8/6 bits, conversion 12.5/10.5/8.5/6.5 cycles, sample 1.5 min
// - oversampling ratio from 2 to 256 conversions per output
// - oversampling shift from zero to eight bits, code 0000 to 1000
// - 20-bit sum shifted, rounded to nearest, low 16 bits kept
// - upper bits beyond 16 are discarded without saturation
// - oversampling keeps standard timing; one result every n conversions
// - master triggers slave per the four-bit sync mode field, free or nine modes
// - in sync the slave result is readable through the master data register
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "atosc_defines.vh"
module atosc_ctrl (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire [5:0] regular_timer_event,
	input wire regular_ext_line,
	input wire [5:0] inserted_timer_event,
	input wire inserted_ext_line,
	output reg dma_request,
	input wire dma_ack,
	output reg core_start,
	output reg core_inserted,
	output reg [1:0] core_resolution,
	output reg [7:0] core_conv_half_cycles,
	input wire core_done,
	input wire [11:0] core_data,
	input wire [15:0] slave_data,
	output reg sensor_reference_enable,
	output reg sensor_power_down,
	output reg slave_trigger,
	output reg [3:0] sync_mode
);
	reg [31:0] ctrl;
	reg [31:0] ovs;
	reg [15:0] rdata;
	reg eoc;
	reg busy;
	reg cur_inserted;
	reg wr_pend;
	reg [7:0] wr_addr;
	reg [1:0] sw_pulse;
	wire rtrig;
	wire itrig;
	wire ov_valid;
	wire [15:0] ov_data;
	wire addr_phase;
	wire conv_on;
	wire [1:0] resolution_select;
	reg [7:0] next_conv_half;
	reg [31:0] next_ctrl;
	reg [31:0] next_ovs;
	reg [31:0] next_hrdata;
	reg [3:0] next_sync_mode;
	reg next_eoc;
	wire [15:0] slave_half;
	wire wr_ctrl;
	wire wr_ovs;
	wire wr_stat;
	wire wr_swst;

	assign addr_phase = hsel & hready & htrans[1];
	assign hreadyout = 1'b1; // zero wait states on every access
	assign hresp = 1'b0;
	assign conv_on = ctrl[`ATOSC_CTRL_ON];
	assign resolution_select = ovs[`ATOSC_OVS_RES_HI:`ATOSC_OVS_RES_LO];

	// write strobes from the address held over into the data phase, where hwdata stands
	assign wr_ctrl = wr_pend & (wr_addr == `ATOSC_CTRL_OFS);
	assign wr_ovs = wr_pend & (wr_addr == `ATOSC_OVS_OFS);
	assign wr_stat = wr_pend & (wr_addr == `ATOSC_STAT_OFS);
	assign wr_swst = wr_pend & (wr_addr == `ATOSC_SWST_OFS);

	// write data arrives one cycle after the address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_phase & hwrite;
			wr_addr <= haddr;
		end
	end

	// value of each register after a write in the current data phase; the read
	// mux uses the same values so a read right behind a write is not stale
	always @* begin
		next_ctrl = ctrl;
		next_ovs = ovs;
		if (wr_ctrl) begin
			next_ctrl = hwdata & `ATOSC_CTRL_MASK;
		end
		if (wr_ovs) begin
			next_ovs = hwdata & `ATOSC_OVS_MASK;
			// resolution field is frozen while the converter is on
			if (conv_on) begin
				next_ovs[`ATOSC_OVS_RES_HI:`ATOSC_OVS_RES_LO] = resolution_select;
			end
		end
	end

	// control, oversampling and software start registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `ATOSC_CTRL_RST;
			ovs <= `ATOSC_OVS_RST;
			sw_pulse <= 2'h0;
		end else begin
			ctrl <= next_ctrl;
			ovs <= next_ovs;
			// start bits are pulses; nothing is stored, so they read back as zero
			sw_pulse <= wr_swst ? hwdata[1:0] : 2'h0;
		end
	end

	// regular group trigger selection
	atosc_trig_sel u_regular_trig (
		.hclk(hclk),
		.hresetn(hresetn),
		.timer_event(regular_timer_event),
		.ext_line(regular_ext_line),
		.software_start(sw_pulse[`ATOSC_SWST_REG]),
		.trigger_select(ctrl[`ATOSC_CTRL_RSEL_HI:`ATOSC_CTRL_RSEL_LO]),
		.trigger_enable(ctrl[`ATOSC_CTRL_RTE]),
		.trigger_pulse(rtrig)
	);

	// inserted group trigger selection
	atosc_trig_sel u_inserted_trig (
		.hclk(hclk),
		.hresetn(hresetn),
		.timer_event(inserted_timer_event),
		.ext_line(inserted_ext_line),
		.software_start(sw_pulse[`ATOSC_SWST_INS]),
		.trigger_select(ctrl[`ATOSC_CTRL_ISEL_HI:`ATOSC_CTRL_ISEL_LO]),
		.trigger_enable(ctrl[`ATOSC_CTRL_ITE]),
		.trigger_pulse(itrig)
	);

	// conversion phase length in half cycles from the resolution code
	always @* begin
		case (resolution_select)
			2'h0: next_conv_half = `ATOSC_TCONV_12_HALF;
			2'h1: next_conv_half = `ATOSC_TCONV_10_HALF;
			2'h2: next_conv_half = `ATOSC_TCONV_8_HALF;
			default: next_conv_half = `ATOSC_TCONV_6_HALF;
		endcase
	end

	// codes above the last combined mode fall back to free mode; the start logic
	// uses this same value so the slave strobe and the mode output always agree
	always @* begin
		if (ctrl[`ATOSC_CTRL_SYNC_HI:`ATOSC_CTRL_SYNC_LO] > `ATOSC_SYNC_LAST) begin
			next_sync_mode = `ATOSC_SYNC_FREE;
		end else begin
			next_sync_mode = ctrl[`ATOSC_CTRL_SYNC_HI:`ATOSC_CTRL_SYNC_LO];
		end
	end

	// start strobes toward the core and master-to-slave trigger
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_start <= 1'b0;
			core_inserted <= 1'b0;
			core_resolution <= 2'h0;
			core_conv_half_cycles <= `ATOSC_TCONV_12_HALF;
			busy <= 1'b0;
			cur_inserted <= 1'b0;
			slave_trigger <= 1'b0;
			sync_mode <= `ATOSC_SYNC_FREE;
		end else begin
			core_start <= 1'b0;
			slave_trigger <= 1'b0;
			core_resolution <= resolution_select;
			core_conv_half_cycles <= next_conv_half;
			sync_mode <= next_sync_mode;
			if (core_done) begin
				busy <= 1'b0;
			end
			// inserted wins when both groups fire together
			if (conv_on && (itrig || rtrig) && (!busy || core_done)) begin
				core_start <= 1'b1;
				core_inserted <= itrig;
				cur_inserted <= itrig;
				busy <= 1'b1;
				slave_trigger <= (next_sync_mode != `ATOSC_SYNC_FREE);
			end
		end
	end

	// oversampling applies to regular results only
	atosc_oversample u_oversample (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(ovs[`ATOSC_OVS_EN]),
		.oversample_ratio(ovs[`ATOSC_OVS_RATIO_HI:`ATOSC_OVS_RATIO_LO]),
		.oversample_shift(ovs[`ATOSC_OVS_SHIFT_HI:`ATOSC_OVS_SHIFT_LO]),
		.sample_valid(core_done & ~cur_inserted),
		.sample_data(core_data),
		.result_valid(ov_valid),
		.result_data(ov_data)
	);

	// a new result beats a software clear in the same cycle
	always @* begin
		next_eoc = eoc;
		if (ov_valid) begin
			next_eoc = 1'b1;
		end else if (wr_stat && !hwdata[0]) begin
			next_eoc = 1'b0;
		end
	end

	// regular result register, end flag and dma request
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata <= 16'h0000;
			eoc <= 1'b0;
			dma_request <= 1'b0;
		end else begin
			if (ov_valid) begin
				rdata <= ov_data;
			end
			eoc <= next_eoc;
			// request held until the dma controller acknowledges the read or dma enable is cleared
			if (ov_valid && ctrl[`ATOSC_CTRL_DMA]) begin
				dma_request <= 1'b1;
			end else if (dma_ack || !ctrl[`ATOSC_CTRL_DMA]) begin
				dma_request <= 1'b0;
			end
		end
	end

	// sensor and reference channel gating
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sensor_reference_enable <= 1'b0;
			sensor_power_down <= 1'b1;
		end else begin
			sensor_reference_enable <= ctrl[`ATOSC_CTRL_TSV];
			sensor_power_down <= ~ctrl[`ATOSC_CTRL_TSV];
		end
	end

	// read mux; a write whose data phase overlaps this address phase is forwarded,
	// since back to back transfers are allowed and would otherwise read stale
	always @* begin
		next_hrdata = 32'h00000000;
		case (haddr)
			`ATOSC_CTRL_OFS: begin
				next_hrdata = next_ctrl;
			end
			`ATOSC_OVS_OFS: begin
				next_hrdata = next_ovs;
			end
			`ATOSC_STAT_OFS: begin
				next_hrdata = {30'h0000000, busy, next_eoc};
			end
			`ATOSC_RDATA_OFS: begin
				next_hrdata = {slave_half, rdata};
			end
			default: begin
				next_hrdata = 32'h00000000;
			end
		endcase
	end

	// slave half-word joins in upper half in sync modes only
	assign slave_half = (sync_mode != `ATOSC_SYNC_FREE) ? slave_data : 16'h0000;

	// read data is registered at the address phase; unmapped reads give zero
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= next_hrdata;
		end
	end
endmodule // atosc_ctrl

//--- bench/atosc_ctrl_sva.sv
// assertions on the converter control top ports
`timescale 1ns/1ps
module atosc_ctrl_chk (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire dma_request,
	input wire core_start,
	input wire core_done,
	input wire [1:0] core_resolution,
	input wire [7:0] core_conv_half_cycles,
	input wire sensor_reference_enable,
	input wire sensor_power_down,
	input wire slave_trigger,
	input wire [3:0] sync_mode
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// a start in any non-free mode must also start the slave
	sequence sync_start_s;
		core_start && sync_mode != 4'h0;
	endsequence
	// a result leaves the core two edges before its request rises
	sequence result_walk_s;
		$past(core_done, 2);
	endsequence
	bus_ready_a: assert property (hreadyout == 1'b1) else $error("wait state");
	bus_okay_a: assert property (hresp == 1'b0) else $error("error response");
	sensor_power_a: assert property (sensor_power_down == !sensor_reference_enable)
		else $error("sensor power state wrong");
	conv_time_a: assert property (core_conv_half_cycles == 8'd25 - 8'd4 * core_resolution)
		else $error("conversion phase mismatch");
	start_pulse_a: assert property (core_start |=> !core_start)
		else $error("start longer than a pulse");
	slave_pair_a: assert property (sync_start_s |-> slave_trigger)
		else $error("slave not started");
	slave_only_a: assert property (slave_trigger |-> sync_start_s)
		else $error("stray slave start");
	sync_range_a: assert property (sync_mode <= 4'h9)
		else $error("sync mode out of range");
	dma_walk_a: assert property ($rose(dma_request) |-> result_walk_s)
		else $error("request without result");
endmodule // atosc_ctrl_chk

bind atosc_ctrl atosc_ctrl_chk chk_u (.hclk, .hresetn, .hreadyout, .hresp, .dma_request,
	.core_start, .core_done, .core_resolution, .core_conv_half_cycles,
	.sensor_reference_enable, .sensor_power_down, .slave_trigger, .sync_mode);

//--- bench/atosc_far_model.sv
// converter core and dma controller seen from the far side
`timescale 1ns/1ps
module atosc_far_model (
	input wire hclk,
	input wire hresetn,
	input wire core_start,
	input wire [7:0] core_conv_half_cycles,
	input wire [11:0] level,
	input wire dma_slow,
	input wire dma_request,
	output reg core_done,
	output reg [11:0] core_data,
	output reg dma_ack
);
	reg [7:0] cnt;
	reg [3:0] wait_cnt;
	// sample plus conversion phase; data line shows the inverse when not valid
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 8'h00;
			core_done <= 1'b0;
			core_data <= 12'hFFF;
		end else begin
			if (core_start)
				cnt <= (core_conv_half_cycles + 8'd3) >> 1;
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			core_done <= (cnt == 8'h01);
			core_data <= (cnt == 8'h01) ? level : ~level;
		end
	end
	// dma answers each request once, promptly or after a stall
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_cnt <= 4'h0;
			dma_ack <= 1'b0;
		end else if (!dma_request || dma_ack) begin
			wait_cnt <= 4'h0;
			dma_ack <= 1'b0;
		end else if (wait_cnt == (dma_slow ? 4'hA : 4'h0))
			dma_ack <= 1'b1;
		else
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule // atosc_far_model

//--- bench/atosc_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "atosc_defines.vh"
module testbench;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [7:0] haddr = 8'h00;
	reg [1:0] htrans = 2'b00;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h00000000;
	reg [5:0] rte = 6'h00;
	reg [5:0] ite = 6'h00;
	reg rx = 1'b0;
	reg ix = 1'b0;
	reg [11:0] level = 12'h000;
	reg dma_slow = 1'b0;
	reg dma_q = 1'b0;
	wire hreadyout, hresp, dma_request, dma_ack, core_start, core_inserted, core_done;
	wire sensor_reference_enable, sensor_power_down, slave_trigger;
	wire [31:0] hrdata;
	wire [1:0] core_resolution;
	wire [7:0] core_conv_half_cycles;
	wire [11:0] core_data;
	wire [3:0] sync_mode;
	integer mismatches = 0, n_checks = 0, starts = 0, dones = 0, dmas = 0, cyc = 0;
	integer i;
	reg [31:0] rv;
	always #4 hclk = ~hclk;
	atosc_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .regular_timer_event(rte),
		.regular_ext_line(rx), .inserted_timer_event(ite), .inserted_ext_line(ix),
		.dma_request, .dma_ack, .core_start, .core_inserted, .core_resolution,
		.core_conv_half_cycles, .core_done, .core_data, .slave_data(16'hA5C3),
		.sensor_reference_enable, .sensor_power_down, .slave_trigger, .sync_mode);
	atosc_far_model far (.hclk, .hresetn, .core_start, .core_conv_half_cycles, .level,
		.dma_slow, .dma_request, .core_done, .core_data, .dma_ack);
	// event counts and the hang limit
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		starts <= starts + core_start;
		dones <= dones + core_done;
		dma_q <= dma_request;
		dmas <= dmas + (dma_request & ~dma_q);
		if (cyc == 60000) begin
			mismatches = mismatches + 1;
			test_done;
		end
	end
	task test_done;
		begin
			$display("checks %0d mismatches %0d", n_checks, mismatches);
			if (mismatches == 0 && n_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("MISMATCH %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// one single ahb transfer; read data taken at the closing edge
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge hclk);
			hsel <= 1'b1;
			haddr <= a;
			htrans <= 2'b10;
			hwrite <= w;
			do @(posedge hclk); while (hreadyout !== 1'b1);
			hsel <= 1'b0;
			htrans <= 2'b00;
			hwdata <= d;
			do @(posedge hclk); while (hreadyout !== 1'b1);
			rv = hrdata;
		end
	endtask
	// raise every other source first, then the selected one, held past completion
	task fire(input g, input [2:0] c);
		integer s, d;
		begin
			s = starts;
			d = dones;
			if (g) ite <= ~(6'h01 << c);
			else rte <= ~(6'h01 << c);
			if (g) ix <= (c != 3'h6);
			else rx <= (c != 3'h6);
			repeat (12) @(posedge hclk);
			#1 chk("unselected source", s, starts);
			if (c == 3'h7) bus(1'b1, `ATOSC_SWST_OFS, {30'h0, g, !g});
			else if (c == 3'h6 && g) ix <= 1'b1;
			else if (c == 3'h6) rx <= 1'b1;
			else if (g) ite[c] <= 1'b1;
			else rte[c] <= 1'b1;
			while (dones == d) @(posedge hclk);
			repeat (12) @(posedge hclk);
			rte <= 6'h00;
			ite <= 6'h00;
			rx <= 1'b0;
			ix <= 1'b0;
			repeat (12) @(posedge hclk);
			#1 chk("starts", s + 1, starts);
			chk("group", g, core_inserted);
		end
	endtask
	// software starts until one oversampled result is requested
	task ovs(input [2:0] r, input [3:0] sh, input [11:0] lv, input [15:0] e);
		integer d, n;
		begin
			level <= lv;
			bus(1'b1, `ATOSC_OVS_OFS, {18'h0, 2'b11, 3'h0, sh, r, 2'b01});
			d = dmas;
			for (i = 0; i < (2 << r); i = i + 1) begin
				chk("early result", d, dmas);
				n = dones;
				bus(1'b1, `ATOSC_SWST_OFS, 32'h1);
				while (dones == n) @(posedge hclk);
			end
			while (dmas == d) @(posedge hclk);
			bus(1'b0, `ATOSC_RDATA_OFS, 32'h0);
			chk("oversampled", e, rv[15:0]);
		end
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, `ATOSC_CTRL_OFS, 32'h0);
		chk("ctrl reset", `ATOSC_CTRL_RST, rv);
		bus(1'b0, `ATOSC_OVS_OFS, 32'h0);
		chk("ovs reset", `ATOSC_OVS_RST, rv);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rv);
		chk("sensor off", 1'b1, sensor_power_down);
		// resolution table while the converter is off
		for (i = 0; i < 4; i = i + 1) begin
			bus(1'b1, `ATOSC_OVS_OFS, i << 12);
			repeat (3) @(posedge hclk);
			#1 chk("conv phase", 25 - 4 * i, core_conv_half_cycles);
			chk("resolution", i, core_resolution);
		end
		bus(1'b1, `ATOSC_CTRL_OFS, 32'h4);
		repeat (3) @(posedge hclk);
		#1 chk("sensor enable", 1'b1, sensor_reference_enable);
		chk("sensor power", 1'b0, sensor_power_down);
		bus(1'b1, `ATOSC_CTRL_OFS, 32'h19);
		bus(1'b1, `ATOSC_OVS_OFS, 32'h1000);
		bus(1'b0, `ATOSC_OVS_OFS, 32'h0);
		chk("resolution locked", 2'h3, rv[13:12]);
		for (i = 0; i < 8; i = i + 1) begin
			bus(1'b1, `ATOSC_CTRL_OFS, 32'h19 | (i << 8));
			fire(1'b0, i);
			bus(1'b1, `ATOSC_CTRL_OFS, 32'h19 | (i << 12));
			fire(1'b1, i);
		end
		chk("no request", 0, dmas);
		bus(1'b1, `ATOSC_CTRL_OFS, 32'h71B);
		level <= 12'h5A3;
		for (i = 0; i < 2; i = i + 1) begin
			dma_slow <= i;
			fire(1'b0, 3'h7);
			bus(1'b0, `ATOSC_RDATA_OFS, 32'h0);
			chk("raw result", 16'h05A3, rv[15:0]);
			chk("requests", i + 1, dmas);
		end
		bus(1'b0, `ATOSC_STAT_OFS, 32'h0);
		chk("end flag", 32'h1, rv);
		bus(1'b1, `ATOSC_STAT_OFS, 32'h0);
		bus(1'b0, `ATOSC_STAT_OFS, 32'h0);
		chk("end flag cleared", 32'h0, rv);
		ovs(3'h1, 4'h1, 12'hFFF, 16'h1FFE);
		ovs(3'h0, 4'h2, 12'h001, 16'h0001);
		ovs(3'h2, 4'h8, 12'h800, 16'h0040);
		ovs(3'h7, 4'h0, 12'hFFF, 16'hFF00);
		bus(1'b1, `ATOSC_OVS_OFS, 32'h3000);
		bus(1'b1, `ATOSC_CTRL_OFS, 32'h3071B);
		fire(1'b0, 3'h7);
		chk("sync mode", 4'h3, sync_mode);
		bus(1'b0, `ATOSC_RDATA_OFS, 32'h0);
		chk("slave result", 16'hA5C3, rv[31:16]);
		bus(1'b1, `ATOSC_CTRL_OFS, 32'hA071B);
		repeat (3) @(posedge hclk);
		#1 chk("bad sync", 4'h0, sync_mode);
		test_done;
	end
endmodule // testbench
